// ==== subtract_unit.v ====
// Function
// - literal-form opcode computes literal minus accumulator into the accumulator with all five flags.
// - register-form opcode computes register minus accumulator and updates all five flags.
// - destination bit 0 sends the difference to the accumulator, register untouched.
// - destination bit 1 writes the difference back into the addressed register.
// - bank bit 0 resolves the address inside the access bank.
// - bank bit 1 prefixes the bank select register to the address.
// - bank bit 0 with extended set on and address up to 95 uses indexed literal offset mode.
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`include "subtract_unit_defines.vh"
module subtract_unit #(
    parameter MEM_AW = 12
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    output wire [7:0]  acc_o
);
    // data memory lives here since no outside bus carries it
    reg [7:0]        mem [0:(1<<MEM_AW)-1];
    reg [7:0]        acc_reg;
    reg [5:0]        status_reg;
    reg [3:0]        bank_reg;
    reg [MEM_AW-1:0] index_reg;
    reg              ext_reg;
    reg [MEM_AW-1:0] maddr_reg;

    wire access = cyc_i & stb_i & ~ack_o;
    wire wr     = access & we_i & sel_i[0];
    wire exec   = wr & (adr_i == `REG_INSTR);

    // instruction decode
    wire [15:0] ins      = dat_i[15:0];
    wire        is_lit   = (ins[15:8] == `OP_LIT_HI);
    wire        is_file  = (ins[15:10] == `OP_FILE_HI);
    wire        dest_bit = ins[9];
    wire        bank_bit = ins[8];
    wire [7:0]  fld      = ins[7:0];

    // operand address resolution
    reg [MEM_AW-1:0] faddr;
    always @* begin
        if (bank_bit) begin
            faddr = {bank_reg, fld};
        end else if (ext_reg && fld <= `IDX_LIMIT) begin
            faddr = index_reg + {{(MEM_AW-8){1'b0}}, fld};
        end else if (fld < `ACCESS_SPLIT) begin
            faddr = {4'h0, fld};
        end else begin
            faddr = {`ACCESS_HI_BANK, fld};
        end
    end

    // shared subtractor: minuend - acc as minuend + ~acc + 1
    function [12:0] sub8;
        input [7:0] m;
        input [7:0] s;
        reg   [8:0] full;
        reg   [4:0] low;
        reg         v;
        begin
            full = {1'b0, m} + {1'b0, ~s} + 9'h001;
            low  = {1'b0, m[3:0]} + {1'b0, ~s[3:0]} + 5'h01;
            v    = (m[7] ^ s[7]) & (m[7] ^ full[7]);
            // flags: n, ov, z, dc, c; carry means no borrow
            sub8 = {full[7:0], full[7], v, (full[7:0] == 8'h00), low[4], full[8]};
        end
    endfunction

    wire [7:0]  fval    = mem[faddr];
    wire [7:0]  minuend = is_lit ? fld : fval;
    wire [12:0] res     = sub8(minuend, acc_reg);
    wire [7:0]  diff    = res[12:5];

    assign acc_o = acc_reg;

    // register writes and instruction execution
    always @(posedge clk_i) begin
        if (rst_i) begin
            acc_reg    <= `ACC_RESET;
            status_reg <= 6'h00;
            bank_reg   <= 4'h0;
            index_reg  <= {MEM_AW{1'b0}};
            ext_reg    <= 1'b0;
            maddr_reg  <= {MEM_AW{1'b0}};
        end else if (exec) begin
            if (is_lit || is_file) begin
                // n ov z dc c, carry set when no borrow
                status_reg <= {1'b0, res[4], res[3], res[2], res[1], res[0]};
                if (is_lit || !dest_bit) begin
                    acc_reg <= diff;
                end
            end else begin
                status_reg[`ST_ILLEGAL] <= 1'b1;  // unknown opcode, state kept
            end
        end else if (wr) begin
            case (adr_i)
                `REG_CTRL:   ext_reg   <= dat_i[`CTRL_EXT];
                `REG_ACC:    acc_reg   <= dat_i[7:0];
                `REG_STATUS: status_reg <= dat_i[5:0];
                `REG_BANK:   bank_reg  <= dat_i[3:0];
                `REG_INDEX:  index_reg <= dat_i[MEM_AW-1:0];
                `REG_ADDR:   maddr_reg <= dat_i[MEM_AW-1:0];
                default:     ;
            endcase
        end
    end

    // data memory: write-back path and software window; no reset on the array
    always @(posedge clk_i) begin
        if (!rst_i && exec && is_file && dest_bit) begin
            mem[faddr] <= diff;
        end else if (!rst_i && wr && adr_i == `REG_DATA) begin
            mem[maddr_reg] <= dat_i[7:0];
        end
    end

    // one-cycle answer; unmapped reads return zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= access;
            if (access) begin
                case (adr_i)
                    `REG_CTRL:   dat_o <= {31'h0, ext_reg};
                    `REG_ACC:    dat_o <= {24'h0, acc_reg};
                    `REG_STATUS: dat_o <= {26'h0, status_reg};
                    `REG_BANK:   dat_o <= {28'h0, bank_reg};
                    `REG_INDEX:  dat_o <= {{(32-MEM_AW){1'b0}}, index_reg};
                    `REG_ADDR:   dat_o <= {{(32-MEM_AW){1'b0}}, maddr_reg};
                    `REG_DATA:   dat_o <= {24'h0, mem[maddr_reg]};
                    default:     dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// ==== subtract_unit_bench.sv ====
`timescale 1ns/100ps
module subtract_unit_bench;
    reg         clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    reg  [7:0]  adr_i = 8'h00;
    reg  [3:0]  sel_i = 4'hF;
    reg  [31:0] dat_i = 32'h0, got;
    wire [31:0] dat_o;
    wire        ack_o;
    wire [7:0]  acc_o;
    integer     miscompares = 0, checks = 0;
    always #5 clk_i = ~clk_i;
    subtract_unit subtract_unit_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .acc_o(acc_o));
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // classic cycle, held until ack is sampled, then one idle cycle
    task wb(input w, input [7:0] a, input [31:0] d);
        begin
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            we_i <= w;
            adr_i <= a;
            dat_i <= d;
            @(posedge clk_i);
            while (ack_o !== 1'b1) @(posedge clk_i);
            got = dat_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            wb(1'b0, a, 32'h0);
            chk(got, exp);
        end
    endtask
    task mem(input [11:0] a, input [7:0] d);
        begin
            wb(1'b1, 8'h18, {20'h0, a});
            wb(1'b1, 8'h1C, {24'h0, d});
        end
    endtask
    // status expected for m minus s: N OV Z DC C
    function [31:0] st(input [7:0] m, input [7:0] s);
        reg [7:0] r;
        begin
            r = m - s;
            st = {27'h0, r[7], m[7] != s[7] && r[7] != m[7], r == 8'h00, m[3:0] >= s[3:0], m >= s};
        end
    endfunction
    task lit(input [7:0] k, input [7:0] w);
        begin
            wb(1'b1, 8'h08, {24'h0, w});
            wb(1'b1, 8'h04, {16'h0, 8'h08, k});
            rd(8'h08, {24'h0, k - w});
            rd(8'h0C, st(k, w));
        end
    endtask
    task fop(input [15:0] op, input [7:0] a, input [31:0] exp);
        begin
            wb(1'b1, 8'h04, {16'h0, op});
            rd(a, exp);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks=%0d miscompares=%0d", checks, miscompares);
            if (miscompares == 0 && checks > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h08, 32'h0);
        lit(8'h02, 8'h01);
        lit(8'h02, 8'h02);
        lit(8'h02, 8'h03);
        lit(8'h80, 8'h01);
        lit(8'h10, 8'h01);
        mem(12'h030, 8'h05);
        wb(1'b1, 8'h08, 32'h03);
        fop(16'h5C30, 8'h08, 32'h02);
        rd(8'h1C, 32'h05);
        rd(8'h0C, st(8'h05, 8'h03));
        fop(16'h5E30, 8'h1C, 32'h03);
        mem(12'hF80, 8'h07);
        fop(16'h5C80, 8'h08, 32'h05);
        wb(1'b1, 8'h10, 32'h2);
        mem(12'h280, 8'h09);
        fop(16'h5D80, 8'h08, 32'h04);
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b1, 8'h14, 32'h100);
        mem(12'h15F, 8'h20);
        fop(16'h5C5F, 8'h08, 32'h1C);
        fop(16'hFFFF, 8'h0C, st(8'h20, 8'h04) | 32'h20);
        rd(8'h20, 32'h0);
        // read back the ctrl, instr, bank, index and address registers once
        rd(8'h00, 32'h1);
        rd(8'h04, 32'h0);
        rd(8'h10, 32'h2);
        rd(8'h14, 32'h100);
        rd(8'h18, 32'h15F);
        // mid-run reset must clear acc, status, bank and index
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0);
        rd(8'h00, 32'h0);
        // the literal path still works after reset; it takes no operand from memory
        lit(8'h05, 8'h05);
        report_and_stop;
    end
    // watchdog well beyond the expected run
    initial begin
        #20000;
        miscompares = miscompares + 1;
        report_and_stop;
    end
endmodule

// ==== subtract_unit_checker.sv ====
`timescale 1ns/100ps
module subtract_unit_checker (
    input wire        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
    input wire [7:0]  adr_i, acc_o,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i, dat_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request is taken only while no answer is pending
    wire take = cyc_i && stb_i && !ack_o;
    wire go   = take && we_i && sel_i[0] && adr_i == 8'h04;
    wire accw = take && we_i && sel_i[0] && adr_i == 8'h08;
    a_lit_result: assert property (go && dat_i[15:8] == 8'h08
        |=> acc_o == $past(dat_i[7:0]) - $past(acc_o)) else $error("bad literal result");
    a_reg_dest_keeps: assert property (go && dat_i[15:9] == 7'h2F
        |=> $stable(acc_o)) else $error("acc changed on register dest");
    a_ack_follows: assert property (take |=> ack_o) else $error("no ack");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_acc_load: assert property (accw |=> acc_o == $past(dat_i[7:0])) else $error("acc load");
    a_acc_hold: assert property (!(go || accw) |=> $stable(acc_o)) else $error("acc moved");
    a_acc_read: assert property (take && !we_i && adr_i == 8'h08
        |=> dat_o == {24'h000000, acc_o}) else $error("acc read");
    a_hole_zero: assert property (take && !we_i && adr_i == 8'h20
        |=> dat_o == 32'h00000000) else $error("unmapped read");
    cover property (go && dat_i[15:8] == 8'h08);
    cover property (go && dat_i[15:10] == 6'h17);
    cover property (take && !we_i);
endmodule
bind subtract_unit subtract_unit_checker subtract_unit_checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .adr_i(adr_i), .acc_o(acc_o),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o));

// ==== subtract_unit_defines.vh ====
`ifndef SUBTRACT_UNIT_DEFINES_VH
`define SUBTRACT_UNIT_DEFINES_VH
// register byte addresses
`define REG_CTRL        8'h00
`define REG_INSTR       8'h04
`define REG_ACC         8'h08
`define REG_STATUS      8'h0C
`define REG_BANK        8'h10
`define REG_INDEX       8'h14
`define REG_ADDR        8'h18
`define REG_DATA        8'h1C
// opcode fields
`define OP_LIT_HI       8'h08
`define OP_FILE_HI      6'h17
`define IDX_LIMIT       8'h5F
// access bank split point and upper page
`define ACCESS_SPLIT    8'h60
`define ACCESS_HI_BANK  4'hF
// status bit positions
`define ST_C            0
`define ST_DC           1
`define ST_Z            2
`define ST_OV           3
`define ST_N            4
`define ST_ILLEGAL      5
// control bit positions and accumulator reset value
`define CTRL_EXT        0
`define ACC_RESET       8'h00
`endif
